// ### inc/cot_regs.svh
`ifndef COT_REGS_SVH
`define COT_REGS_SVH

// ****************************************
// Storage layout and digit codes
// ****************************************
`define MEM_TOP      16'hEA5F
`define MOD_SIZE     16'h4E20
`define DG_RM        4'hA
`define DG_BLANK     4'hC
`define DG_GM        4'hF

// ****************************************
// Unit geometry and timing
// ****************************************
`define CARD_COLS    8'h50
`define PRT_NARROW   8'h78
`define PRT_WIDE     8'h90
`define CLK_NS       40
`define PRT_LOAD_NS  2100000
`define CARD_LOAD_NS 1700000
`define PRT_LOAD_CYC  (`PRT_LOAD_NS / `CLK_NS)
`define CARD_LOAD_CYC (`CARD_LOAD_NS / `CLK_NS)
// Busy cycles of one position, taken off the pace wait
`define DUMP_STEP_CYC  3'h3
`define ALPHA_STEP_CYC 3'h5
`define FILL_STEP_CYC  3'h1

`endif

// ### inc/cot_pkg.sv
package cot_pkg;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        U_TAPE = 3'h0,
        U_TYPE = 3'h1,
        U_CARD = 3'h2,
        U_PRT  = 3'h3,
        U_PLOT = 3'h4
    } unit_t;

    typedef enum logic [1:0] {
        K_DATA  = 2'h0,
        K_EOL   = 2'h1,
        K_BLANK = 2'h2
    } kind_t;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_READ = 6'h02,
        S_TAKE = 6'h04,
        S_PUSH = 6'h08,
        S_FILL = 6'h10,
        S_EOL  = 6'h20
    } state_t;

    typedef struct packed {
        state_t          state;
        logic            dump;
        unit_t           unit;
        logic            wide;
        logic [15:0]     addr;
        logic [15:0]     mod_end;
        logic [3:0]      zone;
        logic            phase;
        kind_t           kind;
        logic [7:0]      data;
        logic [7:0]      pos;
        logic            past_end;
        logic [15:0]     pace;
        logic [2:0]      sync;
        logic            rel;
        logic [1:0][9:0] fifo;
        logic [1:0]      cnt;
        logic            wp;
        logic            rp;
        logic            done;
    } st_t;

endpackage

// ### core/character_output_transfer.sv
`timescale 1ns/1ns
`include "cot_regs.svh"

module character_output_transfer #(
    parameter int PRT_LOAD_CYC  = `PRT_LOAD_CYC,
    parameter int CARD_LOAD_CYC = `CARD_LOAD_CYC
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            rst_n,
    // Instruction start
    input  wire logic            start,
    input  wire logic            op_dump,
    input  wire cot_pkg::unit_t  unit,
    input  wire logic            wide_prt,
    input  wire logic [15:0]     start_addr,
    output logic                 busy,
    output logic                 done,
    // Operator release key pin
    input  wire logic            release_key,
    // Core storage read port, data one cycle after mem_rd
    output logic                 mem_rd,
    output logic [15:0]          mem_addr,
    input  wire logic [4:0]      mem_digit,
    // Character stream to the selected unit
    output logic                 out_valid,
    input  wire logic            out_ready,
    output cot_pkg::kind_t       out_kind,
    output logic [7:0]           out_data
);
    import cot_pkg::*;

    st_t s;
    st_t next_s;

    // ****************************************
    // Helpers
    // ****************************************

    // Step upward through storage, top wraps to zero
    // Every sequencer read after the first goes through here, dump and alpha alike
    function automatic logic [15:0] step(input logic [15:0] a);
        step = (a == `MEM_TOP) ? 16'h0000 : 16'(a + 16'h0001);
    endfunction

    // Last address of the module holding a
    // Only plain dumps stop there; card and printer dumps run past it
    function automatic logic [15:0] mod_last(input logic [15:0] a);
        if (a < `MOD_SIZE) begin
            mod_last = 16'(`MOD_SIZE - 16'h0001);
        end else if (a < 16'(`MOD_SIZE * 2)) begin
            mod_last = 16'(`MOD_SIZE * 2 - 1);
        end else begin
            mod_last = `MEM_TOP;
        end
    endfunction

    // Printer line length
    function automatic logic [7:0] width(input logic w);
        width = w ? `PRT_WIDE : `PRT_NARROW;
    endfunction

    // Wait between buffer positions, less the cycles that the reads and
    // the push of one position take themselves, so a whole card or print
    // line lands in the load time; punch, typewriter and plotter are
    // paced by ready alone
    function automatic logic [15:0] pace_of(input unit_t u, input logic w,
                                            input logic [2:0] ovh);
        logic [15:0] per;
        if (u == U_CARD) begin
            per = 16'(CARD_LOAD_CYC / 80);
        end else if (u == U_PRT) begin
            per = w ? 16'(PRT_LOAD_CYC / 144)
                    : 16'(PRT_LOAD_CYC / 120);
        end else begin
            per = 16'h0000;
        end
        // A period shorter than the overhead leaves no wait at all
        pace_of = (per > {13'h0, ovh}) ? 16'(per - {13'h0, ovh})
                                       : 16'h0000;
    endfunction

    // Dump character: digit with flag, printer gets graphic codes
    // Codes with no printer graphic come out as a space
    function automatic logic [7:0] dump_char(input logic [4:0] d,
                                             input logic prt);
        logic       f;
        logic [3:0] c;
        f = d[4];
        c = d[3:0];
        dump_char = {3'h0, d};
        if (prt) begin
            if (c == `DG_BLANK) begin
                dump_char = f ? 8'h2A : 8'h40;
            end else if (c == `DG_RM) begin
                dump_char = f ? 8'h57 : 8'h23;
            end else if (c == `DG_GM) begin
                dump_char = f ? 8'h58 : 8'h47;
            end else if (c > 4'h9) begin
                dump_char = 8'h20;
            end else if (!f) begin
                dump_char = 8'(8'h30 + c);
            end else if (c == 4'h0) begin
                dump_char = 8'h2D;
            end else begin
                dump_char = 8'(8'h49 + c);
            end
        end
    endfunction

    // ****************************************
    // Outputs
    // ****************************************

    // Buffer head and status straight from state
    // done may lead busy while the buffer still drains
    assign out_valid = (s.cnt != 2'h0);
    assign out_kind  = kind_t'(s.fifo[s.rp][9:8]);
    assign out_data  = s.fifo[s.rp][7:0];
    assign mem_addr  = s.addr;
    assign mem_rd    = (s.state == S_READ) && !s.rel && (s.pace == 16'h0000);
    assign busy      = (s.state != S_IDLE) || out_valid;
    assign done      = s.done;

    // ****************************************
    // Next state
    // ****************************************

    // Sequencer, release synchroniser and two-entry buffer
    always_comb begin
        logic       push;
        logic [9:0] word;
        logic       pop;
        logic       last;
        logic       fin;
        logic       term;
        logic [7:0] npos;
        push   = 1'b0;
        word   = 10'h000;
        fin    = 1'b0;
        next_s = s;
        next_s.done = 1'b0;
        pop  = out_valid && out_ready;
        npos = 8'(s.pos + 8'h01);
        term = (mem_digit[3:0] == `DG_RM) || (mem_digit[3:0] == `DG_GM);
        last = 1'b0;

        // Release key: count a change once the later stages agree
        // so a bouncing key never flickers the release flag
        next_s.sync = {s.sync[1:0], release_key};
        if (s.sync[1] == s.sync[2]) begin
            next_s.rel = s.sync[2];
        end
        if (s.pace != 16'h0000) begin
            next_s.pace = 16'(s.pace - 16'h0001);
        end

        unique case (s.state)
            S_IDLE: begin
                // A start outside idle is ignored, but one while the buffer still drains is taken; callers wait for busy low
                if (start) begin
                    next_s.state    = S_READ;
                    next_s.dump     = op_dump;
                    next_s.unit     = unit;
                    next_s.wide     = wide_prt;
                    next_s.mod_end  = mod_last(start_addr);
                    next_s.pos      = 8'h00;
                    next_s.past_end = 1'b0;
                    next_s.phase    = 1'b0;
                    next_s.pace     = 16'h0000;
                    // Alpha pair begins at the zone digit below P
                    next_s.addr = op_dump ? start_addr
                                          : 16'(start_addr - 16'h0001);
                end
            end
            S_READ: begin
                // Release is honoured only between reads
                if (s.rel) begin
                    fin = 1'b1;
                end else if (s.pace == 16'h0000) begin
                    next_s.state = S_TAKE;
                end
            end
            S_TAKE: begin
                // Digit asked for in the last cycle stands on mem_digit now
                next_s.addr = step(s.addr);
                if (s.dump) begin
                    if (s.addr == s.mod_end) begin
                        next_s.past_end = 1'b1;
                    end
                    next_s.kind  = K_DATA;
                    next_s.data  = dump_char(mem_digit, s.unit == U_PRT);
                    next_s.state = S_PUSH;
                end else if (!s.phase) begin
                    next_s.zone  = mem_digit[3:0];
                    next_s.phase = 1'b1;
                    next_s.state = S_READ;
                end else begin
                    next_s.phase = 1'b0;
                    if (term && s.unit != U_CARD) begin
                        if (s.unit == U_TAPE || s.unit == U_TYPE) begin
                            next_s.state = S_EOL;
                        end else if (s.unit == U_PRT) begin
                            next_s.state = S_FILL;
                        end else begin
                            fin = 1'b1;
                        end
                    end else begin
                        next_s.kind  = K_DATA;
                        // Flags dropped, storage untouched
                        next_s.data  = {s.zone, mem_digit[3:0]};
                        next_s.state = S_PUSH;
                    end
                end
            end
            S_PUSH: begin
                // A full buffer parks the sequencer here; nothing is lost
                if (s.cnt != 2'h2) begin
                    push = 1'b1;
                    word = {s.kind, s.data};
                    next_s.pos   = npos;
                    next_s.pace  = pace_of(s.unit, s.wide,
                                           s.dump ? `DUMP_STEP_CYC
                                                  : `ALPHA_STEP_CYC);
                    next_s.state = S_READ;
                    if (s.unit == U_CARD) begin
                        last = (npos == `CARD_COLS);
                        if (last) begin
                            next_s.pos = 8'h00;
                        end
                        // Dump ends only on a full card
                        if (last && (!s.dump || s.past_end)) begin
                            fin = 1'b1;
                        end
                    end else if (s.unit == U_PRT) begin
                        if (npos == width(s.wide)) begin
                            fin = 1'b1;
                        end
                    end else if (s.dump && s.past_end) begin
                        if (s.unit == U_TAPE) begin
                            next_s.state = S_EOL;
                        end else begin
                            fin = 1'b1;
                        end
                    end
                end
            end
            S_FILL: begin
                // Rest of the print line goes out as blanks
                if (s.pos == width(s.wide)) begin
                    fin = 1'b1;
                end else if (s.cnt != 2'h2 && s.pace == 16'h0000) begin
                    push = 1'b1;
                    word = {K_BLANK, 8'h20};
                    next_s.pos  = npos;
                    next_s.pace = pace_of(s.unit, s.wide, `FILL_STEP_CYC);
                end
            end
            S_EOL: begin
                // End-of-line is a word of its own, then the unit is let go
                if (s.cnt != 2'h2) begin
                    push = 1'b1;
                    word = {K_EOL, 8'h00};
                    fin  = 1'b1;
                end
            end
            default: begin
                // An illegal one-hot code falls back to idle
                next_s.state = S_IDLE;
            end
        endcase

        if (fin) begin
            next_s.state = S_IDLE;
            next_s.done  = 1'b1;
        end

        // Buffer bookkeeping; a full buffer holds the sequencer
        // A push and a pop in one cycle leave the count as it was
        if (push) begin
            next_s.fifo[s.wp] = word;
            next_s.wp = ~s.wp;
        end
        if (pop) begin
            next_s.rp = ~s.rp;
        end
        next_s.cnt = 2'(s.cnt + {1'b0, push} - {1'b0, pop});
    end

    // ****************************************
    // State register
    // ****************************************

    // Synchronous reset to idle with an empty buffer
    // Cleared sync stages make a key held through reset look new
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s       <= '0;
            s.state <= S_IDLE;
        end else begin
            s <= next_s;
        end
    end

endmodule

// ### test/cot_sva.sv
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module cot_sva #(
    parameter int PRT_LOAD_CYC  = 1440,
    parameter int CARD_LOAD_CYC = 800
) (
    // Clock, reset and start
    input wire logic           mclk,
    input wire logic           rst_n,
    input wire logic           start,
    input wire logic           op_dump,
    input wire cot_pkg::unit_t unit,
    input wire logic [15:0]    start_addr,
    input wire logic           busy,
    input wire logic           done,
    input wire logic           release_key,
    // Storage and stream
    input wire logic           mem_rd,
    input wire logic [15:0]    mem_addr,
    input wire logic           out_valid,
    input wire logic           out_ready,
    input wire cot_pkg::kind_t out_kind,
    input wire logic [7:0]     out_data
);
    import cot_pkg::*;
    logic        on, dmp, ended, seen;
    unit_t       um;
    logic [15:0] last, p0;
    int          cyc;

    // Latch the instruction; a module-end read closes a plain dump
    always_ff @(posedge mclk) begin
        if (!rst_n || (start && !busy)) begin
            on    <= rst_n;
            dmp   <= op_dump;
            um    <= unit;
            p0    <= start_addr;
            ended <= 1'b0;
            seen  <= 1'b0;
            cyc   <= 0;
        end else begin
            on    <= on && !done;
            cyc   <= cyc + 1;
            seen  <= seen || mem_rd;
            last  <= mem_rd ? mem_addr : last;
            ended <= ended || (mem_rd && dmp && um != U_CARD
                     && um != U_PRT && mem_addr % 16'h4E20 == 16'h4E1F);
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_first;
        start && !busy |-> ##[1:2] (mem_rd && mem_addr == p0 - 16'(!dmp));
    endproperty
    a_first: assert property (p_first)
        else $error("first read address wrong");
    // Every new read is one place on, wrapping at the top
    property p_step;
        mem_rd && !$past(mem_rd) && seen |->
            mem_addr == (last == 16'hEA5F ? 16'h0000 : last + 16'h0001);
    endproperty
    a_step: assert property (p_step)
        else $error("read address did not step by one");
    property p_hold;
        out_valid && !out_ready |=>
            out_valid && $stable(out_data) && $stable(out_kind);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled word changed");
    property p_release;
        release_key && on |-> ##[1:80] !on;
    endproperty
    a_release: assert property (p_release)
        else $error("release did not end the instruction");
    property p_mod_end;
        ended |-> !(mem_rd && !$past(mem_rd));
    endproperty
    a_mod_end: assert property (p_mod_end)
        else $error("dump read past module end");
    property p_eol;
        out_valid && out_kind == K_EOL |-> out_data == 8'h00;
    endproperty
    a_eol: assert property (p_eol)
        else $error("end-of-line word carries data");
    // Timing bands leave room for stalls of the far side
    property p_card_time;
        done && um == U_CARD |-> cyc >= CARD_LOAD_CYC - CARD_LOAD_CYC / 40
            && cyc <= CARD_LOAD_CYC + 100;
    endproperty
    a_card_time: assert property (p_card_time)
        else $error("card load time out of band");
    property p_prt_time;
        done && um == U_PRT && dmp |-> cyc >= PRT_LOAD_CYC - PRT_LOAD_CYC / 60
            && cyc <= PRT_LOAD_CYC + 100;
    endproperty
    a_prt_time: assert property (p_prt_time)
        else $error("printer load time out of band");
    c_dump: cover property (start && !busy && op_dump);
    c_stall: cover property (out_valid && !out_ready);
    c_prt: cover property (done && um == U_PRT);
endmodule

bind character_output_transfer cot_sva #(
    .PRT_LOAD_CYC (PRT_LOAD_CYC),
    .CARD_LOAD_CYC(CARD_LOAD_CYC)
) u_sva (
    .mclk, .rst_n, .start, .op_dump, .unit, .start_addr, .busy, .done,
    .release_key, .mem_rd, .mem_addr, .out_valid, .out_ready, .out_kind,
    .out_data
);

// ### test/cot_sink.sv
`timescale 1ns/1ns
// ****************************************
// Output unit receiver
// ****************************************
module cot_sink (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Stream handshake
    input  wire logic hold,
    output logic      out_ready = 1'b0
);
    // One stall in four at random; hold stalls fully to fill the buffer
    always @(posedge mclk) begin
        out_ready <= rst_n && !hold && ($urandom % 4 != 0);
    end
endmodule

// ### test/character_output_transfer_bench.sv
`timescale 1ns/1ns
`include "cot_regs.svh"
module character_output_transfer_bench;
    import cot_pkg::*;
    typedef logic [9:0] word_t;
    logic        mclk, rst_n, start, op_dump, wide_prt, release_key, hold;
    logic        busy, done, mem_rd, out_valid, out_ready;
    logic [15:0] start_addr, mem_addr;
    logic [4:0]  mem_digit = 5'h00;
    logic [7:0]  out_data;
    unit_t       unit;
    kind_t       out_kind;
    logic [4:0]  mem [0:59999];
    word_t       exp_q[$], got_q[$];
    int          miscompares, cmp_count;

    character_output_transfer #(
        .PRT_LOAD_CYC (1440),
        .CARD_LOAD_CYC(800)
    ) dut (
        .mclk, .rst_n, .start, .op_dump, .unit, .wide_prt, .start_addr,
        .busy, .done, .release_key, .mem_rd, .mem_addr, .mem_digit,
        .out_valid, .out_ready, .out_kind, .out_data
    );
    cot_sink sink (.mclk, .rst_n, .hold, .out_ready);

    // ****************************************
    // Clock, storage and collection
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Idle storage line toggles, so a late sample never looks valid
    always @(posedge mclk) begin
        mem_digit <= (mem_rd === 1'b1) ? mem[mem_addr] : ~mem_digit;
        if (rst_n && out_valid === 1'b1 && out_ready === 1'b1)
            got_q.push_back({out_kind, out_data});
    end

    function automatic int nx(int a);
        return a == 59999 ? 0 : a + 1;
    endfunction

    // Printer dump glyph; a flag picks the second form
    function automatic logic [7:0] glyph(logic [4:0] g);
        case (g[3:0])
            4'hA: return g[4] ? 8'h57 : 8'h23;
            4'hC: return g[4] ? 8'h2A : 8'h40;
            4'hF: return g[4] ? 8'h58 : 8'h47;
            default: return g[4] ? (g[3:0] == 4'h0 ? 8'h2D : 8'h49 + g[3:0])
                                 : 8'h30 + g[3:0];
        endcase
    endfunction

    // Expected words of one instruction from storage as it stands
    function automatic void build(logic dmp, unit_t u, logic wd, int p);
        int         a;
        int         w;
        logic       past;
        logic [4:0] z;
        logic [4:0] d;
        exp_q.delete();
        w = wd ? 144 : 120;
        a = dmp ? p : p - 1;
        past = 1'b0;
        while (exp_q.size() < 20001) begin
            if (dmp) begin
                d = mem[a];
                past = past || a % 20000 == 19999;
                a = nx(a);
                exp_q.push_back(u == U_PRT ? {K_DATA, glyph(d)}
                                           : {K_DATA, 3'h0, d});
                if (u == U_PRT ? exp_q.size() == w
                    : past && (u != U_CARD || exp_q.size() % 80 == 0))
                    break;
            end else begin
                z = mem[a];
                d = mem[nx(a)];
                a = nx(nx(a));
                if (u != U_CARD && (d[3:0] == `DG_RM || d[3:0] == `DG_GM)) begin
                    if (u <= U_TYPE) exp_q.push_back({K_EOL, 8'h00});
                    break;
                end
                exp_q.push_back({K_DATA, z[3:0], d[3:0]});
                if (exp_q.size() == (u == U_CARD ? 80 : u == U_PRT ? w : 0))
                    break;
            end
        end
        if (dmp && u == U_TAPE) exp_q.push_back({K_EOL, 8'h00});
        while (!dmp && u == U_PRT && exp_q.size() < w)
            exp_q.push_back({K_BLANK, 8'h20});
    endfunction

    task automatic chk(string what, word_t e, word_t g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One instruction: optional release part way, optional full stall
    task automatic run(logic dmp, unit_t u, logic wd, int p, logic rel,
                       logic stall);
        int i;
        build(dmp, u, wd, p);
        got_q.delete();
        @(posedge mclk);
        start      <= 1'b1;
        op_dump    <= dmp;
        unit       <= u;
        wide_prt   <= wd;
        start_addr <= 16'(p);
        @(posedge mclk);
        start <= 1'b0;
        hold  <= stall;
        repeat (stall ? 30 : 2) @(posedge mclk);
        if (stall) chk("valid_held", 10'h1, {9'h0, out_valid});
        hold <= 1'b0;
        if (rel) begin
            repeat (40) @(posedge mclk);
            release_key <= 1'b1;
        end
        for (i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge mclk);
        if (i == 20000) begin
            chk("timeout", 10'h0, 10'h1);
            tally_and_finish();
        end
        release_key <= 1'b0;
        repeat (6) @(posedge mclk);
        if (rel) chk("cut_short", 10'h1, {9'h0, got_q.size() < exp_q.size()});
        else chk("count", 10'(exp_q.size()), 10'(got_q.size()));
        for (i = 0; i < got_q.size() && i < exp_q.size(); i++)
            chk("word", exp_q[i], got_q[i]);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h7B11));
        {rst_n, start, op_dump, wide_prt, release_key, hold} = 6'h00;
        {unit, start_addr} = {U_TAPE, 16'h0000};
        {miscompares, cmp_count} = {32'h0, 32'h0};
        for (int i = 0; i < 60000; i++)
            mem[i] = {1'($urandom % 2), 4'($urandom % 10)};
        {mem[1013], mem[3], mem[111], mem[207], mem[301], mem[409]} =
            {5'h0A, 5'h1F, 5'h0A, 5'h1A, 5'h0A, 5'h0F};
        {mem[5401], mem[59950], mem[59951], mem[59952], mem[59953]} =
            {5'h0F, 5'h0C, 5'h1C, 5'h0A, 5'h1A};
        {mem[59954], mem[59955], mem[59956]} = {5'h0F, 5'h1F, 5'h10};
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        run(0, U_TAPE, 0, 1001, 0, 0);
        run(0, U_TYPE, 0, 59999, 0, 0);
        run(0, U_CARD, 0, 101, 0, 0);
        run(0, U_PRT, 0, 201, 0, 0);
        run(0, U_PRT, 1, 301, 0, 0);
        run(0, U_PLOT, 0, 401, 0, 0);
        run(1, U_TAPE, 0, 19995, 0, 1);
        run(1, U_TYPE, 0, 39997, 0, 0);
        run(1, U_PLOT, 0, 59996, 0, 0);
        run(1, U_CARD, 0, 39990, 0, 0);
        run(1, U_CARD, 0, 59990, 0, 0);
        run(1, U_PRT, 1, 59950, 0, 0);
        run(1, U_PRT, 0, 40000, 0, 0);
        run(0, U_CARD, 0, 2 * ($urandom % 29000) + 1, 0, 0);
        // Random card dump starts within one card of a module end
        run(1, U_CARD, 0, 20000 * ($urandom % 3) + 19920 + $urandom % 80,
            0, 0);
        run(0, U_TAPE, 0, 5001, 1, 0);
        run(1, U_TAPE, 0, 20001, 1, 0);
        tally_and_finish();
    end
endmodule
